//--- instr_exec.sv
// Execution unit for a subset of an 8-bit core's instructions.
// Assumes the decoder presents one instruction per cycle with issue_valid,
// and that the file-register array answers file_rdata combinationally.
// A return with nothing pushed loads an unknown program counter; the stack has no guard.
//
// Contract
// RULE_01: Sleep sets the time-out flag to one and clears the power-down flag.
// RULE_02: Sleep clears the watchdog counter and its prescaler.
// RULE_03: After sleep the core enters sleep, stops the oscillator and executes nothing.
// RULE_04: Return pops the stack into the program counter and changes no flag.
// RULE_05: Return takes two instruction cycles.
// RULE_06: Literal minus accumulator goes to the accumulator; carry, half carry and zero update.
// RULE_07: Register minus accumulator goes to the destination; carry, half carry and zero update.
// RULE_08: Destination bit 0 selects the accumulator, 1 the addressed file register.
// RULE_09: Rotate right moves old carry into bit 7 and bit 0 into carry, only carry changes.
// RULE_10: Nibble swap exchanges the register halves and changes no flag.
// RULE_11: Register XOR of accumulator and register goes to the destination, only zero changes.
// RULE_12: Literal XOR of accumulator and literal goes to the accumulator, only zero changes.
// RULE_13: Zero marks a zero result; subtract carry and half carry mean no borrow.
module instr_exec #(
    parameter int DATA_W = exec_pkg::DATA_W,
    parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic issue_valid,
    input wire logic [3:0] opcode,
    input wire logic [exec_pkg::ADDR_W-1:0] file_addr,
    input wire logic dest_sel,
    input wire logic [DATA_W-1:0] literal,
    input wire logic [exec_pkg::PC_W-1:0] call_target,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic wake,
    output logic issue_ready,
    output logic file_we,
    output logic [exec_pkg::ADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic [DATA_W-1:0] acc,
    output logic carry_flag,
    output logic half_carry_flag,
    output logic zero_flag,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic watchdog_clear,
    output logic osc_run,
    output logic sleeping,
    output logic [exec_pkg::PC_W-1:0] pc
);

    typedef struct packed {
        logic [DATA_W-1:0] res;
        logic c;
        logic dc;
    } sub_res_t;

    // Minuend minus subtrahend with no-borrow carries
    function automatic sub_res_t sub8(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        logic [DATA_W:0] full;
        logic [exec_pkg::NIB_W:0] low;
        sub_res_t r;
        full = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, 1'b1};
        low = {1'b0, a[exec_pkg::NIB_W-1:0]} + {1'b0, ~b[exec_pkg::NIB_W-1:0]}
            + {{exec_pkg::NIB_W{1'b0}}, 1'b1};
        r.res = full[DATA_W-1:0];
        r.c = full[DATA_W];
        r.dc = low[exec_pkg::NIB_W];
        return r;
    endfunction

    // Next sequential address, for fetch advance and for the pushed return address
    function automatic logic [exec_pkg::PC_W-1:0] pc_inc(input logic [exec_pkg::PC_W-1:0] v);
        return v + {{(exec_pkg::PC_W-1){1'b0}}, 1'b1};
    endfunction

    // Stack pointer one step up or down; wraps at the stack depth
    function automatic logic [exec_pkg::STACK_PTR_W-1:0] sp_step(
            input logic [exec_pkg::STACK_PTR_W-1:0] v, input logic up);
        logic [exec_pkg::STACK_PTR_W-1:0] one;
        one = {{(exec_pkg::STACK_PTR_W-1){1'b0}}, 1'b1};
        return up ? v + one : v - one;
    endfunction

    exec_pkg::core_state_t state_r;
    logic [DATA_W-1:0] acc_r;
    logic carry_r;
    logic half_carry_r;
    logic zero_r;
    logic timeout_r;
    logic powerdown_r;
    logic watchdog_clr_r;
    logic file_we_r;
    logic [exec_pkg::ADDR_W-1:0] file_waddr_r;
    logic [DATA_W-1:0] file_wdata_r;
    logic [exec_pkg::PC_W-1:0] pc_r;
    logic [exec_pkg::PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [exec_pkg::STACK_PTR_W-1:0] sp_r;

    logic run;
    exec_pkg::opcode_t op;
    sub_res_t lit_sub;
    sub_res_t reg_sub;
    logic [DATA_W-1:0] result_nxt;
    logic has_result;
    logic to_file;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic c_nxt;
    logic dc_nxt;
    logic [exec_pkg::STACK_PTR_W-1:0] sp_pop;
    logic wr_file;
    logic wr_acc;
    logic sleep_take;
    logic ret_take;
    logic call_take;

    assign op = exec_pkg::opcode_t'(opcode);
    assign run = issue_valid && (state_r == exec_pkg::ST_RUN);
    assign issue_ready = (state_r == exec_pkg::ST_RUN);
    assign lit_sub = sub8(literal, acc_r);
    assign reg_sub = sub8(file_rdata, acc_r);
    assign sp_pop = sp_step(sp_r, 1'b0);
    assign sleep_take = run && (op == exec_pkg::OP_SLEEP);
    assign ret_take = run && (op == exec_pkg::OP_RETURN);
    assign call_take = run && (op == exec_pkg::OP_CALL);
    assign wr_file = run && has_result && to_file;
    assign wr_acc = run && has_result && !to_file;

    // Operand routing and flag update masks for each instruction
    always_comb begin
        result_nxt = acc_r;
        has_result = 1'b0;
        to_file = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        c_nxt = carry_r;
        dc_nxt = half_carry_r;
        unique case (op)
            exec_pkg::literal_minus_acc_op: begin
                result_nxt = lit_sub.res; // [RULE_06]
                has_result = 1'b1;
                {upd_z, upd_c, upd_dc} = 3'h7;
                c_nxt = lit_sub.c; // [RULE_13]
                dc_nxt = lit_sub.dc; // [RULE_13]
            end
            exec_pkg::reg_minus_acc_op: begin
                result_nxt = reg_sub.res; // [RULE_07]
                has_result = 1'b1;
                to_file = (dest_sel == exec_pkg::DEST_FILE);
                {upd_z, upd_c, upd_dc} = 3'h7;
                c_nxt = reg_sub.c; // [RULE_13]
                dc_nxt = reg_sub.dc; // [RULE_13]
            end
            exec_pkg::rotate_right_carry_op: begin
                result_nxt = {carry_r, file_rdata[DATA_W-1:1]}; // [RULE_09]
                has_result = 1'b1;
                to_file = (dest_sel == exec_pkg::DEST_FILE);
                upd_c = 1'b1;
                c_nxt = file_rdata[0]; // [RULE_09]
            end
            exec_pkg::nibble_exchange_op: begin
                result_nxt = {file_rdata[exec_pkg::NIB_W-1:0],
                    file_rdata[DATA_W-1:exec_pkg::NIB_W]}; // [RULE_10]
                has_result = 1'b1;
                to_file = (dest_sel == exec_pkg::DEST_FILE);
            end
            exec_pkg::reg_exclusive_or_op: begin
                result_nxt = acc_r ^ file_rdata; // [RULE_11]
                has_result = 1'b1;
                to_file = (dest_sel == exec_pkg::DEST_FILE);
                upd_z = 1'b1;
            end
            exec_pkg::literal_exclusive_or_op: begin
                result_nxt = acc_r ^ literal; // [RULE_12]
                has_result = 1'b1;
                upd_z = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // Accumulator and file write-back
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_r <= exec_pkg::ZERO_BYTE;
            file_we_r <= 1'b0;
            file_waddr_r <= '0;
            file_wdata_r <= exec_pkg::ZERO_BYTE;
        end else begin
            file_we_r <= wr_file; // [RULE_08]
            if (wr_file) begin
                file_waddr_r <= file_addr;
                file_wdata_r <= result_nxt;
            end
            if (wr_acc) begin
                acc_r <= result_nxt; // [RULE_08]
            end
        end
    end

    // Arithmetic status flags
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            carry_r <= 1'b0;
            half_carry_r <= 1'b0;
            zero_r <= 1'b0;
        end else if (run) begin
            if (upd_c) begin
                carry_r <= c_nxt;
            end
            if (upd_dc) begin
                half_carry_r <= dc_nxt;
            end
            if (upd_z) begin
                zero_r <= (result_nxt == exec_pkg::ZERO_BYTE); // [RULE_13]
            end
        end
    end

    // Power status flags and watchdog clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_r <= exec_pkg::TIMEOUT_RESET;
            powerdown_r <= exec_pkg::POWERDOWN_RESET;
            watchdog_clr_r <= 1'b0;
        end else begin
            // One pulse clears both the watchdog counter and its prescaler
            watchdog_clr_r <= sleep_take; // [RULE_02]
            if (sleep_take) begin
                timeout_r <= exec_pkg::TIMEOUT_ON_SLEEP; // [RULE_01]
                powerdown_r <= exec_pkg::POWERDOWN_ON_SLEEP; // [RULE_01]
            end
        end
    end

    // Sequencer: two-cycle return and sleep
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= exec_pkg::ST_RUN;
        end else begin
            unique case (state_r)
                exec_pkg::ST_RUN: begin
                    if (sleep_take) begin
                        state_r <= exec_pkg::ST_SLEEP; // [RULE_03]
                    end else if (ret_take) begin
                        state_r <= exec_pkg::ST_RET2; // [RULE_05]
                    end
                end
                // Second cycle of a return: issue_ready is low and nothing is taken
                exec_pkg::ST_RET2: state_r <= exec_pkg::ST_RUN; // [RULE_05]
                exec_pkg::ST_SLEEP: begin
                    // The pc was held, so on wake it still holds the address of the sleep instruction
                    if (wake) begin
                        state_r <= exec_pkg::ST_RUN;
                    end
                end
                default: state_r <= exec_pkg::ST_RUN;
            endcase
        end
    end

    // Program counter and call stack
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_r <= exec_pkg::PC_RESET;
            sp_r <= '0;
        end else if (run) begin
            // Sleep holds the pc; every other taken instruction moves it
            if (op == exec_pkg::OP_RETURN) begin
                pc_r <= stack_mem[sp_pop]; // [RULE_04]
                sp_r <= sp_pop; // [RULE_04]
            end else if (op == exec_pkg::OP_CALL) begin
                pc_r <= call_target;
                sp_r <= sp_step(sp_r, 1'b1);
            end else if (op != exec_pkg::OP_SLEEP) begin
                pc_r <= pc_inc(pc_r);
            end
        end
    end

    // Call stack storage; no reset, so a return with no call before it reads an unwritten slot
    always_ff @(posedge ref_clk) begin
        if (call_take) begin
            stack_mem[sp_r] <= pc_inc(pc_r);
        end
    end

    assign acc = acc_r;
    assign file_we = file_we_r;
    assign file_waddr = file_waddr_r;
    assign file_wdata = file_wdata_r;
    assign carry_flag = carry_r;
    assign half_carry_flag = half_carry_r;
    assign zero_flag = zero_r;
    assign timeout_flag = timeout_r;
    assign powerdown_flag = powerdown_r;
    assign watchdog_clear = watchdog_clr_r;
    // Oscillator gate and sleep indication come from one state decode and move together
    assign osc_run = (state_r != exec_pkg::ST_SLEEP); // [RULE_03]
    assign sleeping = (state_r == exec_pkg::ST_SLEEP);
    assign pc = pc_r;

endmodule

//--- exec_pkg.sv
// Package for the instruction-subset execution unit.
// Assumes a single core clock; no bus partner.
package exec_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_W = 3;
    localparam int NIB_W = 4;

    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic TIMEOUT_RESET = 1'b1;
    localparam logic POWERDOWN_RESET = 1'b1;
    localparam logic TIMEOUT_ON_SLEEP = 1'b1;
    localparam logic POWERDOWN_ON_SLEEP = 1'b0;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_SLEEP = 4'h1,
        OP_RETURN = 4'h2,
        literal_minus_acc_op = 4'h3,
        reg_minus_acc_op = 4'h4,
        rotate_right_carry_op = 4'h5,
        nibble_exchange_op = 4'h6,
        reg_exclusive_or_op = 4'h7,
        literal_exclusive_or_op = 4'h8,
        OP_CALL = 4'h9
    } opcode_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_RET2 = 2'b01,
        ST_SLEEP = 2'b10
    } core_state_t;

endpackage

//--- instr_exec_properties.sv
// Concurrent checks on the execution unit's ports.
// Assumes one clock domain and the opcode encoding of exec_pkg.
module instr_exec_properties (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic issue_valid,
    input wire logic [3:0] opcode,
    input wire logic dest_sel,
    input wire logic [7:0] literal,
    input wire logic [7:0] file_rdata,
    input wire logic issue_ready,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] acc,
    input wire logic carry_flag,
    input wire logic half_carry_flag,
    input wire logic zero_flag,
    input wire logic timeout_flag,
    input wire logic powerdown_flag,
    input wire logic watchdog_clear,
    input wire logic osc_run,
    input wire logic sleeping
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire take = issue_valid && issue_ready;
    AST_SLEEP_FLAGS: assert property (
        take && opcode == 4'h1 |=> timeout_flag && !powerdown_flag)
        else $error("sleep status flags wrong");
    AST_SLEEP_WDOG: assert property (
        take && opcode == 4'h1 |=> watchdog_clear ##1 !watchdog_clear)
        else $error("watchdog clear pulse wrong");
    AST_SLEEP_HALT: assert property (sleeping |-> !osc_run && !issue_ready)
        else $error("core runs while sleeping");
    AST_RET_FLAGS: assert property (
        take && opcode == 4'h2 |=> $stable({carry_flag, half_carry_flag, zero_flag}))
        else $error("return changed a flag");
    AST_RET_TWO: assert property (
        take && opcode == 4'h2 |=> !issue_ready ##1 issue_ready)
        else $error("return not two cycles");
    AST_LIT_SUB: assert property (
        take && opcode == 4'h3 |=> acc == 8'($past(literal) - $past(acc))
        && carry_flag == ($past(literal) >= $past(acc)))
        else $error("literal subtract wrong");
    AST_REG_SUB: assert property (
        take && opcode == 4'h4 && dest_sel |=> file_we
        && file_wdata == 8'($past(file_rdata) - $past(acc))
        && zero_flag == (file_wdata == 8'h00))
        else $error("register subtract wrong");
    AST_ROTATE: assert property (
        take && opcode == 4'h5 |=> carry_flag == $past(file_rdata[0]) && $stable(zero_flag))
        else $error("rotate wrong");
    AST_SWAP: assert property (
        take && opcode == 4'h6 && !dest_sel
        |=> acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(carry_flag))
        else $error("swap wrong");
    AST_XOR_FILE: assert property (
        take && opcode == 4'h7 && dest_sel
        |=> file_we && file_wdata == ($past(acc) ^ $past(file_rdata)) && $stable(acc))
        else $error("register xor wrong");
    AST_XOR_LIT: assert property (
        take && opcode == 4'h8 |=> acc == ($past(acc) ^ $past(literal)) && $stable(carry_flag))
        else $error("literal xor wrong");
    cover property (take && opcode == 4'h1);
    cover property (take && opcode == 4'h2);
    cover property (take && opcode == 4'h4 && dest_sel);
endmodule
bind instr_exec instr_exec_properties i_props (.ref_clk, .arst_n, .issue_valid, .opcode,
    .dest_sel, .literal, .file_rdata, .issue_ready, .file_we, .file_wdata, .acc, .carry_flag,
    .half_carry_flag, .zero_flag, .timeout_flag, .powerdown_flag, .watchdog_clear, .osc_run,
    .sleeping);

//--- testbench.sv
// Self-checking bench for the execution unit.
// The bench plays decoder and file-register array itself.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, arst_n, issue_valid, dest_sel, wake;
    logic [3:0] opcode;
    logic [6:0] file_addr, file_waddr;
    logic [7:0] literal, file_rdata, file_wdata, acc;
    logic [12:0] call_target, pc;
    logic issue_ready, file_we, carry_flag, half_carry_flag, zero_flag;
    logic timeout_flag, powerdown_flag, watchdog_clear, osc_run, sleeping;
    int err_count = 0;
    int compares = 0;
    instr_exec i_instr_exec (.ref_clk, .arst_n, .issue_valid, .opcode, .file_addr, .dest_sel,
        .literal, .call_target, .file_rdata, .wake, .issue_ready, .file_we, .file_waddr,
        .file_wdata, .acc, .carry_flag, .half_carry_flag, .zero_flag, .timeout_flag,
        .powerdown_flag, .watchdog_clear, .osc_run, .sleeping, .pc);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // One instruction, taken at the second edge; outputs sampled just after it
    task automatic issue(input logic [3:0] op, input logic d, input logic [7:0] k,
            input logic [7:0] fr);
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        opcode <= op;
        dest_sel <= d;
        literal <= k;
        file_rdata <= fr;
        file_addr <= fr[6:0];
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        #1;
    endtask
    task automatic final_report;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    initial begin
        arst_n = 1'b0;
        {issue_valid, dest_sel, wake} = 3'h0;
        opcode = 4'h0;
        file_addr = 7'h00;
        literal = 8'h00;
        file_rdata = 8'h00;
        call_target = 13'h0123;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        #1;
        chk({timeout_flag, powerdown_flag}, 16'h3);
        issue(4'h8, 1'b0, 8'hA5, 8'h00);
        chk(acc, 16'hA5);
        issue(4'h8, 1'b0, 8'hA5, 8'h00);
        chk({acc, 5'h0, carry_flag, half_carry_flag, zero_flag}, 16'h0001);
        issue(4'h3, 1'b0, 8'h10, 8'h00);
        chk({acc, 5'h0, carry_flag, half_carry_flag, zero_flag}, 16'h1006);
        issue(4'h3, 1'b0, 8'h05, 8'h00);
        chk({acc, 5'h0, carry_flag, half_carry_flag, zero_flag}, 16'hF502);
        issue(4'h4, 1'b1, 8'h00, 8'hF5);
        chk({acc, 5'h0, carry_flag, half_carry_flag, zero_flag}, 16'hF507);
        chk({file_we, file_waddr, file_wdata}, 16'hF500);
        issue(4'h4, 1'b0, 8'h00, 8'h03);
        chk({acc, 5'h0, carry_flag, half_carry_flag, zero_flag}, 16'h0E00);
        chk(file_we, 16'h0);
        issue(4'h5, 1'b0, 8'h00, 8'h81);
        chk({acc, 5'h0, carry_flag, half_carry_flag, zero_flag}, 16'h4004);
        issue(4'h5, 1'b1, 8'h00, 8'h02);
        chk({file_we, 2'h0, carry_flag, file_wdata, acc[3:0]}, 16'h8810);
        issue(4'h6, 1'b1, 8'h00, 8'h3C);
        chk({file_we, 2'h0, carry_flag, file_wdata, acc[3:0]}, 16'h8C30);
        issue(4'h7, 1'b0, 8'h00, 8'h40);
        chk({acc, 5'h0, carry_flag, half_carry_flag, zero_flag}, 16'h0001);
        issue(4'h7, 1'b1, 8'h00, 8'h0F);
        chk({file_wdata, 7'h0, zero_flag}, 16'h0F00);
        chk(acc, 16'h00);
        issue(4'h9, 1'b0, 8'h00, 8'h00);
        chk(pc, 16'h0123);
        issue(4'h2, 1'b0, 8'h00, 8'h00);
        chk({pc, issue_ready, zero_flag}, 16'h0030);
        @(posedge ref_clk);
        #1;
        chk(issue_ready, 16'h1);
        issue(4'h1, 1'b0, 8'h00, 8'h00);
        chk({timeout_flag, powerdown_flag, watchdog_clear}, 16'h5);
        chk({sleeping, osc_run, issue_ready}, 16'h4);
        // An instruction offered while asleep must be ignored
        issue(4'h8, 1'b0, 8'hFF, 8'h00);
        chk({acc, 6'h0, watchdog_clear, sleeping}, 16'h0001);
        @(posedge ref_clk);
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        #1;
        chk({sleeping, osc_run, issue_ready}, 16'h3);
        issue(4'h8, 1'b0, 8'h3C, 8'h00);
        chk(acc, 16'h3C);
        // Reset again in mid-run: the power-down flag cleared by sleep comes back
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        #1;
        chk({acc, pc[4:0], timeout_flag, powerdown_flag, carry_flag}, 16'h0006);
        issue(4'h8, 1'b0, 8'h5A, 8'h00);
        chk(acc, 16'h5A);
        issue(4'h6, 1'b0, 8'h00, 8'h96);
        chk({acc, 7'h0, carry_flag}, 16'h6900);
        final_report();
    end
endmodule
